// ==== capture_timer_pkg.sv ====
// Purpose: Shared constants of the motor capture/compare timer
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Registers are 8 bits wide and sit in the low byte lane
package capture_timer_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_RUN_LO = 8'h08;
  localparam logic [7:0] ADDR_RUN_HI = 8'h0C;
  localparam logic [7:0] ADDR_CMP_LO = 8'h10;
  localparam logic [7:0] ADDR_CMP_HI = 8'h14;
  localparam logic [7:0] ADDR_CAP_LO = 8'h18;
  localparam logic [7:0] ADDR_CAP_HI = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_MASK = 8'h24;

  // Control register 0 fields
  localparam int PAUSE_BIT = 7;
  localparam int CLKSEL_LSB = 4;
  localparam int ON_BIT = 3;
  localparam logic [7:0] CTRL0_WMASK = 8'hFB;

  // Control register 1 fields
  localparam int EDGE_LSB = 6;
  localparam int CAPTURE_INPUT_ENABLE_BIT = 5;
  localparam int FOUR_BIT = 4;
  localparam int DIV4_BIT = 3;
  localparam int FIL_BIT = 2;
  localparam int CLRCAP_BIT = 1;
  localparam int CLRCMP_BIT = 0;

  // Status and mask layout
  localparam int ST_OVF = 0;
  localparam int ST_CMP = 1;
  localparam int ST_CAP = 2;
  localparam int ST_W = 3;

  // Capture edge encodings
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Reset values and limits
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [15:0] CAPT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam int PRESC_W = 7;
  localparam logic [1:0] FILT_DIV_LAST = 2'h3;

endpackage

// ==== hall_filter_if.sv ====
// Purpose: Carries filter controls and detected edges
// Assumes: Same clock on both sides
// Notes: Edge strobes are one-cycle pulses
`timescale 1ns/1ns
interface hall_filter_if;
  logic enable;
  logic four_samples;
  logic div4;
  logic rise;
  logic fall;

  modport filt (
    input enable,
    input four_samples,
    input div4,
    output rise,
    output fall
  );

  modport user (
    output enable,
    output four_samples,
    output div4,
    input rise,
    input fall
  );
endinterface

// ==== hall_filter.sv ====
// Purpose: Synchronise and deglitch the hall capture source
// Assumes: Hall input is asynchronous to the core clock
// Notes: Edges are reported in the same cycle the filtered level changes
`timescale 1ns/1ns
module hall_filter (
  input wire logic clk,
  input wire logic rst,
  input wire logic hall_in,
  hall_filter_if.filt fi
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [3:0] hist;
    logic [1:0] div;
    logic level;
    logic level_prev;
  } filt_s;

  filt_s st_r;
  filt_s st_nxt;
  logic samp_tick;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = hall_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.div = st_r.div + 2'h1;
    // Sample at full rate or every fourth clock see (RULE6)
    samp_tick = !fi.div4 || (st_r.div == capture_timer_pkg::FILT_DIV_LAST);
    if (samp_tick) begin
      st_nxt.hist = {st_r.hist[2:0], st_r.sync2};
    end
    st_nxt.level_prev = st_r.level;
    if (!fi.enable) begin
      st_nxt.level = st_r.sync2;
    end else if (fi.four_samples) begin
      // Level moves only after a run of equal samples see (RULE5)
      if (st_r.hist == {4{~st_r.level}}) begin
        st_nxt.level = ~st_r.level;
      end
    end else if (st_r.hist[1:0] == {2{~st_r.level}}) begin
      st_nxt.level = ~st_r.level;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fi.rise = st_r.level && !st_r.level_prev;
  assign fi.fall = !st_r.level && st_r.level_prev;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_filter_two_run: assert property ( // see (RULE5)
    ($changed(st_r.level) && $past(fi.enable) && !$past(fi.four_samples))
    |-> $past(st_r.hist[1:0]) == {2{st_r.level}})
    else $error("filtered level moved without two equal samples");

  chk_filter_four_run: assert property ( // see (RULE5)
    ($changed(st_r.level) && $past(fi.enable) && $past(fi.four_samples))
    |-> $past(st_r.hist) == {4{st_r.level}})
    else $error("filtered level moved without four equal samples");

  chk_sample_div4: assert property ( // see (RULE6)
    (fi.div4 && samp_tick ##1 fi.div4) |-> !samp_tick)
    else $error("divided sampling ticked on consecutive clocks");

endmodule

// ==== motor_capture_timer.sv ====
// Purpose: 16-bit count-up capture/compare timer for motor control
// Assumes: APB slave, zero wait states, 125 MHz CORE_CLK
// Notes: Status bits clear on read; IRQ is a level
// Operation
// (RULE1) Compare value is two writable bytes, both zero after reset.
// (RULE2) Captured count is two read-only bytes, undefined until a capture.
// (RULE3) One hall capture input, active on rising, falling or both edges.
// (RULE4) Counter runs only when on; captures also need capture enable.
// (RULE5) With the filter on, an edge counts after 2 or 4 equal samples.
// (RULE6) Filter samples at the system clock or the system clock over 4.
// (RULE7) A valid capture copies the running count into the capture pair.
// (RULE8) Counter overflow sets the overflow flag.
// (RULE9) With clear on capture, the counter restarts from zero after it.
// (RULE10) Counter becoming equal to the compare value sets the match flag.
// (RULE11) With clear on compare, a match resets the counter to zero.
// (RULE12) The compare match is offered as an output to stop the PWM.
// (RULE13) Edge field: 00 off, 01 rising, 10 falling, 11 both.
// (RULE14) Count clock is the system clock divided by 2 to the select.
// (RULE15) Turning on zeroes the counter; turning off keeps its value.
// (RULE16) Pause freezes the counter, which resumes from that value.
// (RULE17) Overflow wraps all ones to zero and counting continues.
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ns
module motor_capture_timer (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic HALL_INPUT,
  output logic COMPARE_MATCH,
  output logic IRQ
);

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [15:0] count;
    logic [15:0] cmp;
    logic [15:0] capt;
    logic [2:0] status;
    logic [2:0] mask;
    logic [6:0] presc;
    logic on_prev;
    logic match;
    logic irq;
    logic [31:0] rdata;
  } timer_s;

  timer_s st_r;
  timer_s st_nxt;
  hall_filter_if fi ();

  logic on, pause, cap_en, tick, on_rise, step;
  logic cap_evt, ovf_evt, match_evt;
  logic setup, access, wr, rd_clear;
  logic [1:0] edge_sel;
  logic [2:0] clk_sel;
  logic [15:0] inc;
  logic [7:0] wbyte;

  function automatic logic [6:0] div_mask(input logic [2:0] sel);
    logic [7:0] m;
    m = (8'h01 << sel) - 8'h01;
    return m[6:0];
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic rise,
                                    input logic fall);
    logic hit;
    hit = 1'b0;
    case (sel)
      capture_timer_pkg::EDGE_RISE: hit = rise;
      capture_timer_pkg::EDGE_FALL: hit = fall;
      capture_timer_pkg::EDGE_BOTH: hit = rise || fall;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == capture_timer_pkg::ADDR_CTRL0
        || a == capture_timer_pkg::ADDR_CTRL1
        || a == capture_timer_pkg::ADDR_RUN_LO
        || a == capture_timer_pkg::ADDR_RUN_HI
        || a == capture_timer_pkg::ADDR_CMP_LO
        || a == capture_timer_pkg::ADDR_CMP_HI
        || a == capture_timer_pkg::ADDR_CAP_LO
        || a == capture_timer_pkg::ADDR_CAP_HI
        || a == capture_timer_pkg::ADDR_STATUS
        || a == capture_timer_pkg::ADDR_MASK;
  endfunction

  assign on = st_r.ctrl0[capture_timer_pkg::ON_BIT];
  assign pause = st_r.ctrl0[capture_timer_pkg::PAUSE_BIT];
  assign clk_sel = st_r.ctrl0[capture_timer_pkg::CLKSEL_LSB +: 3];
  assign cap_en = st_r.ctrl1[capture_timer_pkg::CAPTURE_INPUT_ENABLE_BIT];
  assign edge_sel = st_r.ctrl1[capture_timer_pkg::EDGE_LSB +: 2];

  // Filter only runs while the module is on see (RULE5)
  assign fi.enable = on && st_r.ctrl1[capture_timer_pkg::FIL_BIT];
  assign fi.four_samples = st_r.ctrl1[capture_timer_pkg::FOUR_BIT];
  assign fi.div4 = st_r.ctrl1[capture_timer_pkg::DIV4_BIT];

  hall_filter i_hall_filter (
    .clk(CORE_CLK),
    .rst(RST),
    .hall_in(HALL_INPUT),
    .fi(fi.filt)
  );

  always_comb begin
    st_nxt = st_r;
    setup = PSEL && !PENABLE;
    access = PSEL && PENABLE;
    wr = access && PWRITE && mapped(PADDR);
    rd_clear = access && !PWRITE && PADDR == capture_timer_pkg::ADDR_STATUS;
    wbyte = PWDATA[7:0];

    // Prescaler restarts on every off period see (RULE14)
    tick = (st_r.presc & div_mask(clk_sel)) == div_mask(clk_sel);
    st_nxt.presc = on ? st_r.presc + 7'h01 : '0;
    on_rise = on && !st_r.on_prev;
    st_nxt.on_prev = on;
    step = on && !pause && tick && !on_rise; // see (RULE4) see (RULE16)
    inc = st_r.count + 16'h0001; // see (RULE17)
    ovf_evt = step
        && st_r.count == capture_timer_pkg::COUNT_MAX; // see (RULE8)
    match_evt = step && inc == st_r.cmp; // see (RULE10)
    cap_evt = on && cap_en
        && edge_hit(edge_sel, fi.rise, fi.fall); // see (RULE3) see (RULE13)

    if (step) begin
      // Zero compare matches on the wrap see (RULE11)
      if (match_evt && st_r.ctrl1[capture_timer_pkg::CLRCMP_BIT]) begin
        st_nxt.count = '0;
      end else begin
        st_nxt.count = inc;
      end
    end
    if (cap_evt) begin
      st_nxt.capt = st_r.count; // see (RULE7)
      if (st_r.ctrl1[capture_timer_pkg::CLRCAP_BIT]) begin
        st_nxt.count = '0; // see (RULE9)
      end
    end
    if (on_rise) begin
      st_nxt.count = '0; // see (RULE15)
    end

    if (wr) begin
      case (PADDR)
        capture_timer_pkg::ADDR_CTRL0:
          st_nxt.ctrl0 = wbyte & capture_timer_pkg::CTRL0_WMASK;
        capture_timer_pkg::ADDR_CTRL1: st_nxt.ctrl1 = wbyte;
        capture_timer_pkg::ADDR_CMP_LO: st_nxt.cmp[7:0] = wbyte; // see (RULE1)
        capture_timer_pkg::ADDR_CMP_HI: st_nxt.cmp[15:8] = wbyte; // see (RULE1)
        capture_timer_pkg::ADDR_MASK:
          st_nxt.mask = wbyte[capture_timer_pkg::ST_W-1:0];
        default: st_nxt.mask = st_r.mask;
      endcase
    end

    // Read data is taken in setup so it stands through access
    if (setup && !PWRITE) begin
      st_nxt.rdata = '0;
      case (PADDR)
        capture_timer_pkg::ADDR_CTRL0: st_nxt.rdata[7:0] = st_r.ctrl0;
        capture_timer_pkg::ADDR_CTRL1: st_nxt.rdata[7:0] = st_r.ctrl1;
        capture_timer_pkg::ADDR_RUN_LO: st_nxt.rdata[7:0] = st_r.count[7:0];
        capture_timer_pkg::ADDR_RUN_HI: st_nxt.rdata[7:0] = st_r.count[15:8];
        capture_timer_pkg::ADDR_CMP_LO: st_nxt.rdata[7:0] = st_r.cmp[7:0];
        capture_timer_pkg::ADDR_CMP_HI: st_nxt.rdata[7:0] = st_r.cmp[15:8];
        capture_timer_pkg::ADDR_CAP_LO:
          st_nxt.rdata[7:0] = st_r.capt[7:0]; // see (RULE2)
        capture_timer_pkg::ADDR_CAP_HI:
          st_nxt.rdata[7:0] = st_r.capt[15:8]; // see (RULE2)
        capture_timer_pkg::ADDR_STATUS:
          st_nxt.rdata[capture_timer_pkg::ST_W-1:0] = st_r.status;
        capture_timer_pkg::ADDR_MASK:
          st_nxt.rdata[capture_timer_pkg::ST_W-1:0] = st_r.mask;
        default: st_nxt.rdata = '0;
      endcase
    end

    // Only bits already reported are cleared, so a new event survives
    if (rd_clear) begin
      st_nxt.status = st_r.status & ~st_r.rdata[capture_timer_pkg::ST_W-1:0];
    end
    st_nxt.status[capture_timer_pkg::ST_OVF] =
        st_nxt.status[capture_timer_pkg::ST_OVF] || ovf_evt;
    st_nxt.status[capture_timer_pkg::ST_CMP] =
        st_nxt.status[capture_timer_pkg::ST_CMP] || match_evt;
    st_nxt.status[capture_timer_pkg::ST_CAP] =
        st_nxt.status[capture_timer_pkg::ST_CAP] || cap_evt;
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    st_nxt.match = match_evt; // see (RULE12)
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_r.ctrl0 <= capture_timer_pkg::CTRL_RST;
      st_r.ctrl1 <= capture_timer_pkg::CTRL_RST;
      st_r.count <= '0;
      st_r.cmp <= capture_timer_pkg::CMP_RST;
      st_r.capt <= capture_timer_pkg::CAPT_RST;
      st_r.status <= '0;
      st_r.mask <= '0;
      st_r.presc <= '0;
      st_r.on_prev <= 1'b0;
      st_r.match <= 1'b0;
      st_r.irq <= 1'b0;
      st_r.rdata <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PRDATA = st_r.rdata;
  assign PREADY = 1'b1;
  assign PSLVERR = access && !mapped(PADDR);
  assign COMPARE_MATCH = st_r.match;
  assign IRQ = st_r.irq;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  chk_compare_low_write: assert property ( // see (RULE1)
    (wr && PADDR == capture_timer_pkg::ADDR_CMP_LO)
    |=> st_r.cmp[7:0] == $past(PWDATA[7:0]))
    else $error("compare low byte not written");

  chk_compare_high_write: assert property ( // see (RULE1)
    (wr && PADDR == capture_timer_pkg::ADDR_CMP_HI)
    |=> st_r.cmp[15:8] == $past(PWDATA[7:0]))
    else $error("compare high byte not written");

  chk_capture_copy: assert property ( // see (RULE7)
    cap_evt |=> st_r.capt == $past(st_r.count)
      && st_r.status[capture_timer_pkg::ST_CAP])
    else $error("capture did not copy the count");

  chk_capture_gate: assert property ( // see (RULE4)
    cap_evt |-> on && cap_en && edge_sel != capture_timer_pkg::EDGE_OFF)
    else $error("capture taken while disabled");

  chk_rise_only: assert property ( // see (RULE13)
    (cap_evt && edge_sel == capture_timer_pkg::EDGE_RISE) |-> fi.rise)
    else $error("rising mode captured a falling edge");

  chk_fall_only: assert property ( // see (RULE13)
    (cap_evt && edge_sel == capture_timer_pkg::EDGE_FALL) |-> fi.fall)
    else $error("falling mode captured a rising edge");

  chk_capture_hold: assert property ( // see (RULE2)
    !cap_evt |=> $stable(st_r.capt))
    else $error("captured count moved without a capture");

  chk_capture_clear: assert property ( // see (RULE9)
    (cap_evt && st_r.ctrl1[capture_timer_pkg::CLRCAP_BIT])
    |=> st_r.count == 16'h0000)
    else $error("counter not cleared after capture");

  chk_overflow_wrap: assert property ( // see (RULE8)
    ovf_evt |=> st_r.count == 16'h0000
      && st_r.status[capture_timer_pkg::ST_OVF]
      ##1 st_r.irq || !st_r.mask[capture_timer_pkg::ST_OVF]
      || $past(rd_clear))
    else $error("overflow did not wrap and flag");

  chk_match_flag: assert property ( // see (RULE10)
    match_evt |=> st_r.status[capture_timer_pkg::ST_CMP] && COMPARE_MATCH
      ##1 !COMPARE_MATCH || $past(match_evt))
    else $error("compare match not flagged");

  chk_match_clear: assert property ( // see (RULE11)
    (match_evt && st_r.ctrl1[capture_timer_pkg::CLRCMP_BIT] && !cap_evt)
    |=> st_r.count == 16'h0000)
    else $error("counter not cleared on compare match");

  chk_on_rise_zero: assert property ( // see (RULE15)
    $rose(on) |=> st_r.count == 16'h0000)
    else $error("counter not zeroed when turned on");

  chk_off_pause_hold: assert property ( // see (RULE16)
    ((!on || pause) && !cap_evt && !$rose(on)) |=> $stable(st_r.count))
    else $error("counter moved while off or paused");

  chk_div2_rate: assert property ( // see (RULE14)
    (on && tick && clk_sel == 3'h1 ##1 on && clk_sel == 3'h1) |-> !tick)
    else $error("divide by two ticked on consecutive clocks");

  cov_capture_clear: cover property (
    cap_evt && st_r.ctrl1[capture_timer_pkg::CLRCAP_BIT]);
  cov_compare_match: cover property (match_evt ##1 IRQ);
  cov_overflow: cover property (ovf_evt);
  cov_filtered_capture: cover property (cap_evt && fi.enable);
  cov_slow_match: cover property (match_evt && clk_sel == 3'h7);

endmodule

// ==== hall_sensor_model.sv ====
// Purpose: Hall sensor source feeding the capture input pin
// Assumes: Level changes launched from core clock rising edges
// Notes: Pin is always driven, so no release level is modelled
`timescale 1ns/1ns
module hall_sensor_model (
  input wire logic clk,
  output logic hall
);
  initial hall = 1'b0;

  task automatic level(input logic v);
    @(posedge clk);
    hall <= v;
  endtask

  // High for exactly w core cycles
  task automatic pulse(input int w);
    level(1'b1);
    repeat (w) @(posedge clk);
    hall <= 1'b0;
  endtask
endmodule

// ==== tb_motor_capture_timer.sv ====
// Purpose: Self-checking bench of the motor capture/compare timer
// Assumes: Zero wait state APB, every transfer takes three cycles
// Notes: Overflow scenario runs last since it needs a full wrap
`timescale 1ns/1ns
module tb_motor_capture_timer;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h00000000;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic HALL_INPUT;
  logic COMPARE_MATCH;
  logic IRQ;
  logic [31:0] q;
  logic [31:0] a;
  logic serr;
  int n;
  int err_total = 0;
  int checked = 0;

  always #4 CORE_CLK = ~CORE_CLK;

  motor_capture_timer i_motor_capture_timer (
    .CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .HALL_INPUT(HALL_INPUT),
    .COMPARE_MATCH(COMPARE_MATCH), .IRQ(IRQ)
  );
  hall_sensor_model i_hall_sensor_model (.clk(CORE_CLK), .hall(HALL_INPUT));

  task automatic conclude();
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_eq({31'h00000000, got}, {31'h00000000, exp});
  endtask

  // Entered right after a rising edge; idle cycle keeps drives apart
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [7:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= {24'h000000, d};
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    @(posedge CORE_CLK);
    while (PREADY !== 1'b1)
      @(posedge CORE_CLK);
    q = PRDATA;
    serr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    apb(1'b1, ad, d);
  endtask

  task automatic rd(input logic [7:0] ad);
    apb(1'b0, ad, 8'h00);
  endtask

  task automatic wait_match(input int lim);
    n = 0;
    do begin
      @(negedge CORE_CLK);
      n++;
    end while (COMPARE_MATCH !== 1'b1 && n < lim);
    if (n >= lim) begin
      check_bit(1'b0, 1'b1);
    end
  endtask

  task automatic t_regs();
    rd(capture_timer_pkg::ADDR_CMP_LO);
    check_eq(q, 32'h00000000);
    rd(capture_timer_pkg::ADDR_CMP_HI);
    check_eq(q, 32'h00000000);
    wr(capture_timer_pkg::ADDR_CMP_LO, 8'hA5);
    wr(capture_timer_pkg::ADDR_CMP_HI, 8'h3C);
    rd(capture_timer_pkg::ADDR_CMP_LO);
    check_eq(q, 32'h000000A5);
    rd(capture_timer_pkg::ADDR_CMP_HI);
    check_eq(q, 32'h0000003C);
    rd(capture_timer_pkg::ADDR_CAP_HI);
    a = q;
    wr(capture_timer_pkg::ADDR_CAP_HI, ~a[7:0]);
    rd(capture_timer_pkg::ADDR_CAP_HI);
    check_eq(q, a);
    rd(8'h30);
    check_eq(q, 32'h00000000);
    check_bit(serr, 1'b1);
  endtask

  task automatic t_pause();
    wr(capture_timer_pkg::ADDR_CTRL0, 8'h08);
    rd(capture_timer_pkg::ADDR_RUN_LO);
    a = q;
    rd(capture_timer_pkg::ADDR_RUN_LO);
    check_eq(q, {24'h000000, a[7:0] + 8'h03});
    wr(capture_timer_pkg::ADDR_CTRL0, 8'h88);
    rd(capture_timer_pkg::ADDR_RUN_LO);
    a = q;
    rd(capture_timer_pkg::ADDR_RUN_LO);
    check_eq(q, a);
    wr(capture_timer_pkg::ADDR_CTRL0, 8'h08);
    rd(capture_timer_pkg::ADDR_RUN_LO);
    // One step lands before the read latches, so frozen value plus one
    check_eq(q, {24'h000000, a[7:0] + 8'h01});
    a = q;
    rd(capture_timer_pkg::ADDR_RUN_LO);
    check_eq(q, {24'h000000, a[7:0] + 8'h03});
    repeat (100) @(posedge CORE_CLK);
    wr(capture_timer_pkg::ADDR_CTRL0, 8'h00);
    rd(capture_timer_pkg::ADDR_RUN_LO);
    a = q;
    rd(capture_timer_pkg::ADDR_RUN_LO);
    check_eq(q, a);
    wr(capture_timer_pkg::ADDR_CTRL0, 8'h08);
    rd(capture_timer_pkg::ADDR_RUN_LO);
    check_eq(q, 32'h00000000);
  endtask

  task automatic t_compare();
    logic [2:0] sels [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
    wr(capture_timer_pkg::ADDR_CTRL0, 8'h00);
    wr(capture_timer_pkg::ADDR_CMP_LO, 8'h05);
    wr(capture_timer_pkg::ADDR_CMP_HI, 8'h00);
    wr(capture_timer_pkg::ADDR_MASK, 8'h00);
    wr(capture_timer_pkg::ADDR_CTRL1, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(capture_timer_pkg::ADDR_CTRL0, {1'b0, sels[i], 4'h8});
      wait_match(2000);
      wait_match(2000);
      check_eq(n, 5 << sels[i]);
      check_bit(IRQ, 1'b0);
      @(posedge CORE_CLK);
      wr(capture_timer_pkg::ADDR_CTRL0, 8'h00);
    end
  endtask

  // Fifth pass keeps both edges selected but capture input disabled
  task automatic t_edges();
    logic cap;
    wr(capture_timer_pkg::ADDR_CTRL0, 8'h08);
    for (int e = 0; e < 5; e++) begin
      wr(capture_timer_pkg::ADDR_CTRL1, e < 4 ? {e[1:0], 6'h20} : 8'hC0);
      rd(capture_timer_pkg::ADDR_STATUS);
      i_hall_sensor_model.level(1'b1);
      repeat (20) @(posedge CORE_CLK);
      rd(capture_timer_pkg::ADDR_STATUS);
      cap = q[capture_timer_pkg::ST_CAP];
      check_bit(cap, e < 4 && e[0]);
      i_hall_sensor_model.level(1'b0);
      repeat (20) @(posedge CORE_CLK);
      rd(capture_timer_pkg::ADDR_STATUS);
      cap = q[capture_timer_pkg::ST_CAP];
      check_bit(cap, e < 4 && e[1]);
    end
  endtask

  // Rising edges 101 cycles apart, counter cleared at each capture
  task automatic t_period();
    wr(capture_timer_pkg::ADDR_CTRL1, 8'h62);
    i_hall_sensor_model.pulse(10);
    repeat (90) @(posedge CORE_CLK);
    i_hall_sensor_model.pulse(10);
    repeat (30) @(posedge CORE_CLK);
    rd(capture_timer_pkg::ADDR_CAP_LO);
    check_eq(q, 32'h00000064);
    rd(capture_timer_pkg::ADDR_CAP_HI);
    check_eq(q, 32'h00000000);
  endtask

  task automatic t_filter();
    logic [7:0] fc [6] = '{8'h64, 8'h64, 8'h74, 8'h6C, 8'h7C, 8'h60};
    int fw [6] = '{1, 3, 3, 3, 40, 1};
    logic fx [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 6; i++) begin
      wr(capture_timer_pkg::ADDR_CTRL1, fc[i]);
      repeat (20) @(posedge CORE_CLK);
      rd(capture_timer_pkg::ADDR_STATUS);
      i_hall_sensor_model.pulse(fw[i]);
      repeat (60) @(posedge CORE_CLK);
      rd(capture_timer_pkg::ADDR_STATUS);
      check_bit(q[capture_timer_pkg::ST_CAP], fx[i]);
    end
  endtask

  task automatic t_overflow();
    wr(capture_timer_pkg::ADDR_CTRL0, 8'h00);
    wr(capture_timer_pkg::ADDR_CTRL1, 8'h00);
    wr(capture_timer_pkg::ADDR_CMP_LO, 8'h00);
    wr(capture_timer_pkg::ADDR_MASK, 8'h01);
    rd(capture_timer_pkg::ADDR_STATUS);
    wr(capture_timer_pkg::ADDR_CTRL0, 8'h08);
    wait_match(70000);
    check_bit(IRQ, 1'b1);
    @(posedge CORE_CLK);
    rd(capture_timer_pkg::ADDR_STATUS);
    check_eq(q, 32'h00000003);
    @(negedge CORE_CLK);
    check_bit(IRQ, 1'b0);
    @(posedge CORE_CLK);
    rd(capture_timer_pkg::ADDR_RUN_HI);
    check_eq(q, 32'h00000000);
  endtask

  initial begin
    repeat (6) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    t_regs();
    t_pause();
    t_compare();
    t_edges();
    t_period();
    t_filter();
    t_overflow();
    conclude();
  end

  // Full wrap is 65536 cycles, the rest well under 10000
  initial begin
    #640000;
    err_total++;
    conclude();
  end
endmodule
